// ===== rtl/adc_seq_consts.svh
// register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_PINSEL 8'h08
`define OFS_RES_HIGH 8'h0C
`define OFS_RES_LOW 8'h10
`define OFS_IRQ 8'h14
`define CTRL0_CHAN_LSB 0
`define CTRL0_JUSTIFY_BIT 4
`define CTRL0_POWER_BIT 5
`define CTRL0_BUSY_BIT 6
`define CTRL0_START_BIT 7
`define CTRL1_DIV_LSB 0
`define CTRL1_SRC_LSB 5
`define IRQ_FLAG_BIT 0
`define IRQ_ENABLE_BIT 1
`define RST_BYTE 8'h00
`define RST_CHAN 4'h0
`define RST_FIELD3 3'h0
`define SRC_BANDGAP 3'h1
`define SRC_GROUND_A 3'h2
`define SRC_PROTECT 3'h3
`define SRC_GROUND_B 3'h4
`define SAMPLE_LAST_TICK 5'h03
`define CONV_LAST_TICK 5'h0F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/adc_seq_pkg.sv
// types shared by the converter control block
package adc_seq_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_SAMPLE = 3'b010,
		SEQ_CONVERT = 3'b100
	} seq_state_t;
endpackage

// ===== rtl/adc_input_select_and_sequencer.sv
// converter input selection, pin overrides, clock divider, conversion sequencer and axi4-lite registers
//
// Notes on behaviour
// - analog-selected pin loses its digital function and routes to the channel mux
// - pull-high resistor is cut whenever the pin is analog-selected
// - analog select overrides the port direction setting
// - source codes 000, 101, 11x convert the external channel picked by channel select
// - source 001 routes bandgap, source 011 routes protection amplifier output
// - source codes 010 and 100 tie the converter input to ground
// - channel codes 0000 to 0111 pick channels 0 to 7, fewer on small variants
// - channel codes beyond implemented channels leave the input floating
// - a low-high-low pulse on the start bit begins one conversion
// - busy rises as soon as a conversion starts and holds throughout
// - completion clears busy and sets the interrupt request flag
// - with interrupt enabled, completion raises the interrupt output
// - conversion clock is system clock divided by 1 to 128 per field code
// - converter is powered only while the power enable bit is high
// - a conversion is 4 sampling then 12 converting clock periods, then busy clears
// - justify bit selects left or right placement of the 12-bit result
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_input_select_and_sequencer
	import adc_seq_pkg::*;
#(
	parameter int NUM_CHANNELS = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] port_pullup_request,
	input wire logic [7:0] port_dir_output,
	input wire logic [11:0] sar_result,
	output logic [7:0] pin_analog_select,
	output logic [7:0] pin_digital_enable,
	output logic [7:0] pin_pullup_enable,
	output logic [7:0] pin_output_enable,
	output logic [7:0] ext_channel_select,
	output logic route_bandgap,
	output logic route_protect_amp,
	output logic route_ground,
	output logic converter_power_enable,
	output logic conv_clock_tick,
	output logic sample_phase,
	output logic conversion_busy_flag,
	output logic [7:0] result_high_byte,
	output logic [7:0] result_low_byte,
	output logic adc_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// software-visible control state
	logic [3:0] channel_select_field;
	logic result_justify_bit;
	logic power_en;
	logic start_bit;
	logic [2:0] input_source_field;
	logic [2:0] conv_clock_divide_field;
	logic [7:0] analog_pin_select_reg;
	logic irq_enable;
	logic irq_flag;
	logic busy;
	logic conv_done;
	logic [11:0] result_word;
	seq_state_t state;

	// write channel holding slots
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb_q;
	logic do_write;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_pinsel;
	logic wr_irq;
	logic clear_flag;

	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_ctrl0 = do_write && w_strb_q && (aw_addr_q == `OFS_CTRL0);
	assign wr_ctrl1 = do_write && w_strb_q && (aw_addr_q == `OFS_CTRL1);
	assign wr_pinsel = do_write && w_strb_q && (aw_addr_q == `OFS_PINSEL);
	assign wr_irq = do_write && w_strb_q && (aw_addr_q == `OFS_IRQ);
	assign clear_flag = wr_irq && w_data_q[`IRQ_FLAG_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write address and data, taken in either order
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_full <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_q <= `RST_BYTE;
		end else begin
			if (do_write) begin
				aw_full <= 1'b0;
			end else if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			s_axi_awready <= do_write || (!aw_full && !(s_axi_awvalid && s_axi_awready));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			w_full <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_q <= `RST_BYTE;
			w_strb_q <= 1'b0;
		end else begin
			if (do_write) begin
				w_full <= 1'b0;
			end else if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data_q <= s_axi_wdata[7:0]; // registers are a byte wide
				w_strb_q <= s_axi_wstrb[0];
			end
			s_axi_wready <= do_write || (!w_full && !(s_axi_wvalid && s_axi_wready));
		end
	end

	// write response; unmapped addresses answer slverr and change nothing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == `OFS_CTRL0 || aw_addr_q == `OFS_CTRL1 || aw_addr_q == `OFS_PINSEL ||
				aw_addr_q == `OFS_IRQ || aw_addr_q == `OFS_RES_HIGH || aw_addr_q == `OFS_RES_LOW) ?
				`RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers; busy is read-only and ignores writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			channel_select_field <= `RST_CHAN;
			result_justify_bit <= 1'b0;
			power_en <= 1'b0;
			start_bit <= 1'b0;
		end else if (wr_ctrl0) begin
			channel_select_field <= w_data_q[`CTRL0_CHAN_LSB +: 4];
			result_justify_bit <= w_data_q[`CTRL0_JUSTIFY_BIT];
			power_en <= w_data_q[`CTRL0_POWER_BIT];
			start_bit <= w_data_q[`CTRL0_START_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			input_source_field <= `RST_FIELD3;
			conv_clock_divide_field <= `RST_FIELD3;
		end else if (wr_ctrl1) begin
			input_source_field <= w_data_q[`CTRL1_SRC_LSB +: 3];
			conv_clock_divide_field <= w_data_q[`CTRL1_DIV_LSB +: 3];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			analog_pin_select_reg <= `RST_BYTE;
			irq_enable <= 1'b0;
		end else begin
			if (wr_pinsel) begin
				analog_pin_select_reg <= w_data_q;
			end
			if (wr_irq) begin
				irq_enable <= w_data_q[`IRQ_ENABLE_BIT];
			end
		end
	end

	// request flag: write one clears, a completion in the same cycle wins
	// flag on completion
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_flag <= 1'b0;
		end else begin
			irq_flag <= conv_done || (irq_flag && !clear_flag);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read, one outstanding
	logic [7:0] read_byte;
	logic read_hit;
	always_comb begin
		read_byte = `RST_BYTE;
		read_hit = 1'b1;
		case (s_axi_araddr)
			`OFS_CTRL0: read_byte = {start_bit, busy, power_en, result_justify_bit, channel_select_field};
			`OFS_CTRL1: read_byte = {input_source_field, 2'h0, conv_clock_divide_field};
			`OFS_PINSEL: read_byte = analog_pin_select_reg;
			`OFS_RES_HIGH: read_byte = result_high_byte;
			`OFS_RES_LOW: read_byte = result_low_byte;
			`OFS_IRQ: read_byte = {6'h00, irq_enable, irq_flag};
			default: read_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, read_byte};
				s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= (s_axi_rvalid && s_axi_rready) || (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin overrides and channel routing, one copy per pin
	logic ext_source;
	assign ext_source = (input_source_field == 3'h0) || (input_source_field == 3'h5) || input_source_field[2:1] == 2'h3;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			logic sel;
			assign sel = (gi < NUM_CHANNELS) && analog_pin_select_reg[gi];
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					pin_analog_select[gi] <= 1'b0;
					pin_digital_enable[gi] <= 1'b1;
					pin_pullup_enable[gi] <= 1'b0;
					pin_output_enable[gi] <= 1'b0;
					ext_channel_select[gi] <= 1'b0;
				end else begin
					pin_analog_select[gi] <= sel;
					pin_digital_enable[gi] <= !sel;
					pin_pullup_enable[gi] <= port_pullup_request[gi] && !sel;
					pin_output_enable[gi] <= port_dir_output[gi] && !sel;
					// channel decode, codes past the last channel float
					ext_channel_select[gi] <= ext_source && (gi < NUM_CHANNELS) && (channel_select_field == 4'(gi));
				end
			end
		end
	endgenerate

	// internal sources; software keeps channel select at 1xxx for these
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			route_bandgap <= 1'b0;
			route_protect_amp <= 1'b0;
			route_ground <= 1'b0;
		end else begin
			route_bandgap <= input_source_field == `SRC_BANDGAP;
			route_protect_amp <= input_source_field == `SRC_PROTECT;
			route_ground <= (input_source_field == `SRC_GROUND_A) || (input_source_field == `SRC_GROUND_B);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// conversion clock divider; runs only inside a conversion so each one starts phase-aligned
	logic [7:0] div_ratio;
	logic [6:0] div_last;
	logic [6:0] div_cnt;
	logic tick;
	logic start_prev;
	logic start_fall;
	logic [4:0] tick_cnt;

	// divide by two to the field code
	assign div_ratio = 8'h01 << conv_clock_divide_field;
	assign div_last = 7'(div_ratio - 8'h01);
	assign tick = (state != SEQ_IDLE) && (div_cnt == div_last);
	// falling edge of the start bit
	assign start_fall = start_prev && !start_bit;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_cnt <= 7'h00;
		end else if (state == SEQ_IDLE || tick) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_bit;
		end
	end

	// sequencer; start held high or power off aborts without a completion
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= SEQ_IDLE;
			tick_cnt <= 5'h00;
			busy <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			// held in reset while start is high
			if (start_bit || !power_en) begin
				state <= SEQ_IDLE;
				busy <= 1'b0;
				tick_cnt <= 5'h00;
			end else begin
				case (state)
					SEQ_IDLE: begin
						if (start_fall) begin
							state <= SEQ_SAMPLE;
							busy <= 1'b1;
							tick_cnt <= 5'h00;
						end
					end
					SEQ_SAMPLE: begin
						if (tick) begin
							tick_cnt <= tick_cnt + 5'h01;
							if (tick_cnt == `SAMPLE_LAST_TICK) begin
								state <= SEQ_CONVERT;
							end
						end
					end
					SEQ_CONVERT: begin
						if (tick) begin
							tick_cnt <= tick_cnt + 5'h01;
							if (tick_cnt == `CONV_LAST_TICK) begin
								state <= SEQ_IDLE;
								busy <= 1'b0;
								conv_done <= 1'b1;
							end
						end
					end
					default: begin
						state <= SEQ_IDLE;
						busy <= 1'b0;
					end
				endcase
			end
		end
	end

	// result captured at the final edge of the conversion
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			result_word <= 12'h000;
		end else if (state == SEQ_CONVERT && tick && tick_cnt == `CONV_LAST_TICK) begin
			result_word <= sar_result;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs toward the analog core and software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			converter_power_enable <= 1'b0;
			conv_clock_tick <= 1'b0;
			sample_phase <= 1'b0;
			conversion_busy_flag <= 1'b0;
			result_high_byte <= `RST_BYTE;
			result_low_byte <= `RST_BYTE;
			adc_irq <= 1'b0;
		end else begin
			converter_power_enable <= power_en;
			conv_clock_tick <= tick;
			sample_phase <= state == SEQ_SAMPLE;
			conversion_busy_flag <= busy;
			result_high_byte <= result_justify_bit ? {4'h0, result_word[11:8]} : result_word[11:4];
			result_low_byte <= result_justify_bit ? result_word[7:0] : {result_word[3:0], 4'h0};
			adc_irq <= irq_flag && irq_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_start;
		start_fall && power_en && !start_bit;
	endsequence
	sequence s_busy_then_sample;
		busy ##1 sample_phase;
	endsequence

	a_start_sets_busy: assert property (s_start |=> s_busy_then_sample)
		else $error("busy or sampling did not follow a start pulse");
	a_done_clears_busy: assert property (conv_done |-> !busy && $past(tick_cnt) == 5'h0F)
		else $error("completion without sixteen periods or with busy set");
	a_done_sets_flag: assert property (conv_done |=> irq_flag)
		else $error("completion did not set the request flag");
	a_irq_follows_flag: assert property (irq_flag && irq_enable |=> adc_irq)
		else $error("enabled request did not raise the interrupt");
	a_pullup_cut: assert property (pin_analog_select[0] |-> !pin_pullup_enable[0] && !pin_digital_enable[0])
		else $error("analog pin kept pull-high or digital function");
	a_dir_override: assert property (analog_pin_select_reg[0] && port_dir_output[0] |=> !pin_output_enable[0])
		else $error("direction not overridden on analog pin");
	a_ground_route: assert property (input_source_field == `SRC_GROUND_A |=> route_ground && ext_channel_select == 8'h00)
		else $error("ground source not routed alone");
	a_bandgap_route: assert property (input_source_field == `SRC_BANDGAP |=> route_bandgap && !route_protect_amp)
		else $error("bandgap source not routed");
	a_ext_route: assert property (ext_source && channel_select_field == 4'h0 |=> ext_channel_select == 8'h01)
		else $error("external channel zero not routed");
	a_float_high: assert property (channel_select_field[3] |=> ext_channel_select == 8'h00)
		else $error("high channel code connected a pin");
	a_start_held: assert property (start_bit |=> state == SEQ_IDLE && !busy)
		else $error("sequencer ran while start held high");
	a_power_off: assert property (!power_en |=> !converter_power_enable && !busy)
		else $error("converter active while unpowered");
	a_right_justify: assert property (result_justify_bit |=> result_high_byte[7:4] == 4'h0)
		else $error("right-justified high byte has upper bits");
	a_div_by_two: assert property (tick && conv_clock_divide_field == 3'h1 && $stable(conv_clock_divide_field)
		&& !conv_done ##1 (state != SEQ_IDLE) |-> !tick ##1 tick)
		else $error("divide-by-two tick spacing wrong");

endmodule
`default_nettype wire

// ===== testbench/adc_core_model.sv
// behavioural analog core model that drives the conversion result bus
`timescale 1ns/10ps
`default_nettype none
module adc_core_model (
	input wire logic clk_sys,
	input wire logic converter_power_enable,
	input wire logic conversion_busy_flag,
	input wire logic [11:0] held_value,
	output logic [11:0] sar_result
);
	logic [11:0] churn = 12'h000;
	// outside a conversion the bus churns every cycle, so a badly timed capture cannot match
	always @(posedge clk_sys) begin
		churn <= ~churn + 12'h5A3;
	end
	assign sar_result = (converter_power_enable && conversion_busy_flag) ? held_value : churn;
endmodule
`default_nettype wire

// ===== testbench/test_adc_input_select_and_sequencer.sv
// self-checking bench for the converter input select and sequencer block
`timescale 1ns/10ps
`default_nettype none
module test_adc_input_select_and_sequencer;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] port_pullup_request = 8'h00, port_dir_output = 8'h00;
	logic [11:0] sar_result, held = 12'h000;
	logic [7:0] pin_analog_select, pin_digital_enable, pin_pullup_enable, pin_output_enable, ext_channel_select;
	logic route_bandgap, route_protect_amp, route_ground, converter_power_enable, conv_clock_tick;
	logic sample_phase, conversion_busy_flag, adc_irq;
	logic [7:0] result_high_byte, result_low_byte;
	logic [31:0] seed = 32'hF1BF;
	int bad_count = 0;
	int comparisons = 0;

	always #4 clk_sys = ~clk_sys;

	adc_input_select_and_sequencer #(.NUM_CHANNELS(8)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_pullup_request(port_pullup_request),
		.port_dir_output(port_dir_output), .sar_result(sar_result), .pin_analog_select(pin_analog_select),
		.pin_digital_enable(pin_digital_enable), .pin_pullup_enable(pin_pullup_enable),
		.pin_output_enable(pin_output_enable), .ext_channel_select(ext_channel_select),
		.route_bandgap(route_bandgap), .route_protect_amp(route_protect_amp), .route_ground(route_ground),
		.converter_power_enable(converter_power_enable), .conv_clock_tick(conv_clock_tick),
		.sample_phase(sample_phase), .conversion_busy_flag(conversion_busy_flag),
		.result_high_byte(result_high_byte), .result_low_byte(result_low_byte), .adc_irq(adc_irq));

	adc_core_model core_u (.clk_sys(clk_sys), .converter_power_enable(converter_power_enable),
		.conversion_busy_flag(conversion_busy_flag), .held_value(held), .sar_result(sar_result));

	////////////////////////////////////////////////////////////////////////////////
	// helpers: random source, comparison, bus cycles, expectations
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// called right after a rising edge; address and data offered together, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// let an edge pass so a following call never re-raises bready in the same step
		@(posedge clk_sys);
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	// expected routing: {bandgap, protect, ground, external one-hot}
	function automatic logic [10:0] exp_route(input logic [2:0] src, input logic [3:0] chan);
		case (src)
			3'h1: return 11'h400;
			3'h3: return 11'h200;
			3'h2, 3'h4: return 11'h100;
			default: return {3'b000, chan[3] ? 8'h00 : 8'h01 << chan[2:0]};
		endcase
	endfunction

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// one conversion at a given divide code; the long codes also poll busy over the bus
	task automatic convert(input logic [2:0] div);
		logic [1:0] r;
		logic [31:0] rd;
		logic j;
		int busy_n, tick_n, k;
		seed = lfsr_next(seed);
		j = seed[0];
		held <= seed[15:4];
		axi_write(8'h04, {3'h0, 2'h0, div}, r);
		axi_write(8'h14, {6'h00, div[0], 1'b1}, r);
		axi_write(8'h00, {3'b101, j, 4'h0}, r);
		axi_write(8'h00, {3'b001, j, 4'h0}, r);
		busy_n = 0;
		tick_n = 0;
		// the bus poll runs beside the busy count so no busy cycle goes uncounted
		fork
			if (div > 3'h2) begin
				axi_read(8'h00, rd, r);
				check("busy bit", 32'h1, {31'h0, rd[6]});
			end
			for (k = 0; k < 2400 && !(busy_n > 0 && !conversion_busy_flag); k++) begin
				@(negedge clk_sys);
				busy_n += conversion_busy_flag;
				tick_n += conv_clock_tick;
			end
		join
		check("busy length", 16 << div, busy_n);
		check("tick count", 32'd16, tick_n);
		repeat (3) @(posedge clk_sys);
		check("high byte", j ? {28'h0, held[11:8]} : {24'h0, held[11:4]}, {24'h0, result_high_byte});
		check("low byte", j ? {24'h0, held[7:0]} : {24'h0, held[3:0], 4'h0}, {24'h0, result_low_byte});
		axi_read(8'h14, rd, r);
		check("request flag", 32'h1, {31'h0, rd[0]});
		check("irq out", {31'h0, div[0]}, {31'h0, adc_irq});
		axi_write(8'h14, {6'h00, div[0], 1'b1}, r);
		repeat (3) @(posedge clk_sys);
		check("irq cleared", 32'h0, {31'h0, adc_irq});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [1:0] r;
		logic [31:0] rd;
		int s, c;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check("digital enable reset", 32'hFF, {24'h0, pin_digital_enable});
		axi_read(8'h00, rd, r);
		check("ctrl0 reset", 32'h0, rd);
		$display("test reset done");
		for (s = 0; s < 8; s++) begin
			seed = lfsr_next(seed);
			port_pullup_request <= seed[7:0];
			port_dir_output <= seed[15:8];
			axi_write(8'h08, seed[23:16], r);
			repeat (3) @(posedge clk_sys);
			check("analog select", {24'h0, seed[23:16]}, {24'h0, pin_analog_select});
			check("digital enable", {24'h0, ~seed[23:16]}, {24'h0, pin_digital_enable});
			check("pullup", {24'h0, seed[7:0] & ~seed[23:16]}, {24'h0, pin_pullup_enable});
			check("output enable", {24'h0, seed[15:8] & ~seed[23:16]}, {24'h0, pin_output_enable});
		end
		$display("test pin override done");
		// every source code against every channel code; internal sources keep 1xxx
		for (s = 0; s < 8; s++) begin
			for (c = 0; c < 16; c++) begin
				// channel parked at 1xxx before an internal source
				if (s inside {1, 2, 3, 4} && c < 8) continue;
				axi_write(8'h00, {4'h0, c[3:0]}, r);
				axi_write(8'h04, {s[2:0], 5'h00}, r);
				repeat (3) @(posedge clk_sys);
				check("route", exp_route(s[2:0], c[3:0]),
					{route_bandgap, route_protect_amp, route_ground, ext_channel_select});
			end
		end
		$display("test input route done");
		axi_write(8'h00, 8'h20, r);
		repeat (20) @(posedge clk_sys);
		check("power out", 32'h1, {31'h0, converter_power_enable});
		// only codes 6 and 7 give a recommended period at this clock; faster codes time the divider alone
		for (s = 0; s < 8; s++) convert(s[2:0]);
		$display("test conversions done");
		// start held high keeps the sequencer idle
		axi_write(8'h00, 8'hA0, r);
		repeat (40) @(posedge clk_sys);
		check("busy start held", 32'h0, {31'h0, conversion_busy_flag});
		// pulse with power off does nothing
		axi_write(8'h00, 8'h80, r);
		axi_write(8'h00, 8'h00, r);
		repeat (40) @(posedge clk_sys);
		check("busy unpowered", 32'h0, {31'h0, conversion_busy_flag});
		check("power off", 32'h0, {31'h0, converter_power_enable});
		$display("test refusals done");
		axi_read(8'h18, rd, r);
		check("unmapped read resp", 32'h2, {30'h0, r});
		check("unmapped read data", 32'h0, rd);
		axi_write(8'h1C, 8'h55, r);
		check("unmapped write resp", 32'h2, {30'h0, r});
		$display("test unmapped done");
		end_of_test();
	end

	// watchdog: well beyond the roughly six thousand cycles the tests need
	initial begin
		#(40000 * 8);
		bad_count++;
		$display("unexpected watchdog expected finish seen hang");
		end_of_test();
	end
endmodule
`default_nettype wire
